/* File: alt_reset_pulse.sv */
`timescale 1ns/100ps
// one-shot low pulse for the alternate cpu reset, re-armed only by a write of 0
module alt_reset_pulse
  import misc_io_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic bit_write,
  input  wire logic bit_value,
  output logic      rst_n
);
  // ----------------------------------------------------------------
  // pulse sequencer
  // ----------------------------------------------------------------
  pulse_state_t state_q;
  logic [2:0]   cnt_q;
  logic         seen0_q;  // a 0 written while the pulse is still low
  wire          start = bit_write && bit_value && (state_q == PULSE_IDLE);
  wire          rearm = bit_write && !bit_value;

  // done state holds until software writes 0, so repeats need a re-arm
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= PULSE_IDLE;
      cnt_q   <= 3'h0;
      rst_n   <= 1'b1;
      seen0_q <= 1'b0;
    end else begin
      case (state_q)
        PULSE_IDLE: begin
          if (start) begin
            state_q <= PULSE_LOW;
            cnt_q   <= 3'(ALT_RST_CLKS - 1);
            rst_n   <= 1'b0;
            seen0_q <= 1'b0;
          end
        end
        // a 0 written during the pulse is remembered so the re-arm is not lost
        PULSE_LOW: begin
          if (cnt_q == 3'h0) begin
            state_q <= (rearm || seen0_q) ? PULSE_IDLE : PULSE_DONE;
            rst_n   <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
            if (rearm) seen0_q <= 1'b1;
          end
        end
        PULSE_DONE: begin
          if (rearm) begin
            state_q <= PULSE_IDLE;
          end
        end
        default: begin
          state_q <= PULSE_IDLE;
          rst_n   <= 1'b1;
        end
      endcase
    end
  end

  sequence s_low4;
    !rst_n [*4];
  endsequence
  a_pulse_width: assert property (@(posedge clk) disable iff (reset)
    $fell(rst_n) |-> s_low4 ##1 rst_n)
    else $error("alternate reset pulse not four clocks");
  a_no_rearm: assert property (@(posedge clk) disable iff (reset)
    (state_q == PULSE_DONE && !rearm) |=> rst_n)
    else $error("reset pulse without re-arm");
endmodule

/* File: host_io_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host side of the 8-bit i/o cycle
// ----------------------------------------------------------------
module host_io_model (
  input  wire logic        clk,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rdata_valid,
  output logic      [15:0] io_addr,
  output logic      [7:0]  io_wdata,
  output logic             io_rd,
  output logic             io_wr
);
  // idle bus shows inverted values so a decode never leans on a stale address
  initial begin
    io_addr  = 16'hFFFF;
    io_wdata = 8'hFF;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
  end
  // one access: request held over its taking edge, answer sampled just after it
  task automatic cycle(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
    @(posedge clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_rd    = !w;
    io_wr    = w;
    @(posedge clk);
    #1;
    q        = io_rdata;
    v        = io_rdata_valid;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask
endmodule

/* File: misc_io_pkg.sv */
package misc_io_pkg;
  // ----------------------------------------------------------------
  // i/o addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_FAST = 16'h0092;
  localparam logic [15:0] ADDR_RTC_INDEX = 16'h0070;
  localparam logic [15:0] ADDR_RTC_DATA  = 16'h0071;
  localparam logic [15:0] ADDR_FDC_PRI   = 16'h03F2;
  localparam logic [15:0] ADDR_FDC_SEC   = 16'h0372;
  localparam logic [15:0] ADDR_LAST_MG   = 16'h0464;
  localparam logic [15:0] ADDR_CRAM_PAGE = 16'h0C00;
  localparam logic [7:0]  CRAM_BASE_HI   = 8'h08;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          FDC_DMA_EN_BIT = 3;
  localparam int          PSEL_PORT_BIT  = 6;
  localparam int          PF_LIGHT_HI    = 7;
  localparam int          PF_LIGHT_LO    = 6;
  localparam int          PF_PASSWORD    = 3;
  localparam int          PF_A20         = 1;
  localparam int          PF_RESET       = 0;
  localparam logic [7:0]  PORT_RESET_VAL = 8'h24;
  localparam logic [7:0]  PORT_ONES_MASK = 8'h24;
  localparam logic [7:0]  PORT_ZERO_MASK = 8'h10;
  localparam logic [4:0]  PAGE_RESET_VAL = 5'h00;
  localparam logic [6:0]  RTC_PROT_LO    = 7'h36;
  localparam logic [6:0]  RTC_PROT_HI    = 7'h3F;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          ALT_RST_CLKS   = 4;
  typedef enum logic [1:0] {PULSE_IDLE, PULSE_LOW, PULSE_DONE} pulse_state_t;
endpackage

/* File: misc_system_io_ports.sv */
`timescale 1ns/100ps
// miscellaneous 8-bit i/o registers on the isa side
module misc_system_io_ports
  import misc_io_pkg::*;
#(
  parameter int SLOTS = 8
)(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [15:0]      io_addr,
  input  wire logic [7:0]       io_wdata,
  input  wire logic             io_rd,
  input  wire logic             io_wr,
  input  wire logic             port_enable,
  input  wire logic             dack2_n,
  input  wire logic             grant_valid,
  input  wire logic [SLOTS-1:0] grant_onehot,
  output logic      [7:0]       io_rdata,
  output logic                  io_rdata_valid,
  output logic      [4:0]       page_select_out,
  output logic                  xbus_xcvr_out_en_n,
  output logic                  alt_cpu_reset_n,
  output logic                  alt_addr20_gate,
  output logic                  disk_light_n,
  output logic                  rtc_read_strobe_n,
  output logic                  rtc_write_strobe_n
);
  // ----------------------------------------------------------------
  // input synchronisers (pins from outside)
  // ----------------------------------------------------------------
  logic dack_s1_q, dack_s2_q, en_s1_q, en_s2_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      dack_s1_q <= 1'b1;
      dack_s2_q <= 1'b1;
      en_s1_q   <= 1'b0;
      en_s2_q   <= 1'b0;
    end else begin
      dack_s1_q <= dack2_n;
      dack_s2_q <= dack_s1_q;
      en_s1_q   <= port_enable;
      en_s2_q   <= en_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire hit_port  = hit(io_addr, ADDR_PORT_FAST) && en_s2_q;
  wire hit_fdc   = hit(io_addr, ADDR_FDC_PRI) || hit(io_addr, ADDR_FDC_SEC);
  wire hit_page  = hit(io_addr, ADDR_CRAM_PAGE);
  wire hit_lmg   = hit(io_addr, ADDR_LAST_MG);
  wire hit_index = hit(io_addr, ADDR_RTC_INDEX);
  wire hit_data  = hit(io_addr, ADDR_RTC_DATA);
  wire hit_cram  = (io_addr[15:8] == CRAM_BASE_HI);
  wire wr_port   = io_wr && hit_port;
  wire wr_fdc    = io_wr && hit_fdc;
  wire wr_page   = io_wr && hit_page;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]       port_q;
  logic             fdc_dma_en_q;
  logic [4:0]       page_q;
  logic [SLOTS-1:0] last_mg_q;

  // port, floppy gate and page register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      port_q       <= PORT_RESET_VAL;
      fdc_dma_en_q <= 1'b0;
      page_q       <= PAGE_RESET_VAL;
    end else begin
      if (wr_port) port_q <= io_wdata;
      if (wr_fdc) fdc_dma_en_q <= io_wdata[FDC_DMA_EN_BIT];
      if (wr_page) page_q <= io_wdata[4:0];
    end
  end

  // last granted master keeps its undefined start until the first grant
  always_ff @(posedge clk) begin
    if (grant_valid) last_mg_q <= grant_onehot;
  end

  // ----------------------------------------------------------------
  // read path (floppy gate is write-only, so it reads as nothing)
  // ----------------------------------------------------------------
  wire [7:0] port_view = (port_q | PORT_ONES_MASK) & ~PORT_ZERO_MASK;
  wire [7:0] rd_mux    = hit_port ? port_view :
                         hit_page ? {3'h0, page_q} :
                         hit_lmg  ? 8'(last_mg_q) : 8'h00;
  wire       rd_hit    = hit_port || hit_page || hit_lmg;

  always_ff @(posedge clk) begin
    if (reset) begin
      io_rdata       <= 8'h00;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata       <= io_rd ? rd_mux : 8'h00;
      io_rdata_valid <= io_rd && rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  // page lines only move during config ram accesses, holding low otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      page_select_out    <= 5'h00;
      xbus_xcvr_out_en_n <= 1'b1;
      alt_addr20_gate    <= 1'b0;
      disk_light_n       <= 1'b1;
    end else begin
      page_select_out    <= ((io_rd || io_wr) && hit_cram) ? page_q : 5'h00;
      xbus_xcvr_out_en_n <= !(fdc_dma_en_q && !dack_s2_q);
      alt_addr20_gate    <= port_q[PF_A20];
      disk_light_n       <= !(port_q[PF_LIGHT_HI] || port_q[PF_LIGHT_LO]);
    end
  end

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  alt_reset_pulse u_pulse (
    .clk       (clk),
    .reset     (reset),
    .bit_write (wr_port),
    .bit_value (io_wdata[PF_RESET]),
    .rst_n     (alt_cpu_reset_n)
  );

  rtc_guard u_rtc (
    .clk                (clk),
    .reset              (reset),
    .index_write        (io_wr && hit_index),
    .index_data         (io_wdata[6:0]),
    .protect            (port_q[PF_PASSWORD]),
    .rd_req             (io_rd && hit_data),
    .wr_req             (io_wr && hit_data),
    .rtc_read_strobe_n  (rtc_read_strobe_n),
    .rtc_write_strobe_n (rtc_write_strobe_n)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_page_drive: assert property (@(posedge clk) disable iff (reset)
    (io_rd && hit_cram) |=> (page_select_out == $past(page_q)))
    else $error("page lines not driven during cram access");
  a_xbus_gate: assert property (@(posedge clk) disable iff (reset)
    !fdc_dma_en_q ##1 !fdc_dma_en_q |-> xbus_xcvr_out_en_n)
    else $error("transceiver enabled while dma gate off");
  a_light_on: assert property (@(posedge clk) disable iff (reset)
    (port_q[7] || port_q[6]) |=> !disk_light_n)
    else $error("disk light off with light bit set");
  a_read_fixed: assert property (@(posedge clk) disable iff (reset)
    (io_rd && hit_port) |=> (io_rdata[5] && io_rdata[2] && !io_rdata[4]))
    else $error("fixed port bits wrong on read");
  a_port_gate: assert property (@(posedge clk) disable iff (reset)
    (io_wr && !en_s2_q) |=> $stable(port_q))
    else $error("port written while disabled");
  a_a20_follow: assert property (@(posedge clk) disable iff (reset)
    wr_port |=> ##1 (alt_addr20_gate == $past(io_wdata[1], 2)))
    else $error("address-line-20 gate does not follow write");
  a_fdc_bit: assert property (@(posedge clk) disable iff (reset)
    wr_fdc |=> (fdc_dma_en_q == $past(io_wdata[3])))
    else $error("dma enable bit not stored");
  a_page_mask: assert property (@(posedge clk) disable iff (reset)
    wr_page |=> (page_q == $past(io_wdata[4:0])))
    else $error("page field not stored");
endmodule

/* File: misc_system_io_ports_tb.sv */
`timescale 1ns/100ps
module misc_system_io_ports_tb
  import misc_io_pkg::*;
;
  logic        clk, reset, port_enable, dack2_n, grant_valid, io_rd, io_wr, v;
  logic        io_rdata_valid, xbus_xcvr_out_en_n, alt_cpu_reset_n, alt_addr20_gate;
  logic        disk_light_n, rtc_read_strobe_n, rtc_write_strobe_n;
  logic [7:0]  grant_onehot, io_rdata, io_wdata, q;
  logic [15:0] io_addr;
  logic [4:0]  page_select_out;
  int          err_total, total_checks, cyc;
  // ----------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  misc_system_io_ports #(.SLOTS(8)) u_dut (.clk, .reset, .io_addr, .io_wdata, .io_rd,
    .io_wr, .port_enable, .dack2_n, .grant_valid, .grant_onehot, .io_rdata,
    .io_rdata_valid, .page_select_out, .xbus_xcvr_out_en_n, .alt_cpu_reset_n,
    .alt_addr20_gate, .disk_light_n, .rtc_read_strobe_n, .rtc_write_strobe_n);
  host_io_model u_host (.clk, .io_rdata, .io_rdata_valid, .io_addr, .io_wdata, .io_rd,
    .io_wr);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.cycle(1'b1, a, d, q, v);
  endtask
  task automatic rd(input logic [15:0] a);
    u_host.cycle(1'b0, a, 8'h00, q, v);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // watch the reset output over five cycles from the write's taking edge
  task automatic pulse(input logic low);
    for (int i = 0; i < 5; i++) begin
      chk("alt_cpu_reset_n", {7'h0, !(low && i < 4)}, {7'h0, alt_cpu_reset_n});
      tick(1);
    end
  endtask
  // dack goes through two sync flops and a register, so four edges are allowed
  task automatic fdc(input logic [15:0] a, input logic [7:0] d);
    wr(a, d);
    dack2_n = 1'b0;
    tick(4);
    chk("xbus_xcvr_out_en_n", {7'h0, !d[3]}, {7'h0, xbus_xcvr_out_en_n});
    dack2_n = 1'b1;
    tick(4);
    chk("xbus_xcvr_out_en_n idle", 8'h01, {7'h0, xbus_xcvr_out_en_n});
  endtask
  task automatic rtc(input logic [7:0] idx, input logic blk);
    wr(ADDR_RTC_INDEX, idx);
    rd(ADDR_RTC_DATA);
    chk("rtc_read_strobe_n", {7'h0, blk}, {7'h0, rtc_read_strobe_n});
    wr(ADDR_RTC_DATA, 8'h5A);
    chk("rtc_write_strobe_n", {7'h0, blk}, {7'h0, rtc_write_strobe_n});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a hang counts as a mismatch and still reaches the report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reset        = 1'b1;
    port_enable  = 1'b1;
    dack2_n      = 1'b0;
    grant_valid  = 1'b0;
    grant_onehot = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    tick(4);
    chk("xbus_xcvr_out_en_n", 8'h01, {7'h0, xbus_xcvr_out_en_n});
    chk("alt_cpu_reset_n", 8'h01, {7'h0, alt_cpu_reset_n});
    dack2_n = 1'b1;
    rd(ADDR_PORT_FAST);
    chk("port", 8'h24, q);
    rd(ADDR_CRAM_PAGE);
    chk("page", 8'h00, q & 8'h1F);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      logic [7:0] d;
      d = (i == 0) ? 8'hFA : (i == 1) ? 8'h40 : (i == 2) ? 8'h80 : 8'h00;
      wr(ADDR_PORT_FAST, d);
      rd(ADDR_PORT_FAST);
      chk("port", (d | 8'h24) & 8'hEF, q);
      chk("disk_light_n", {7'h0, !(d[7] | d[6])}, {7'h0, disk_light_n});
      chk("alt_addr20_gate", {7'h0, d[1]}, {7'h0, alt_addr20_gate});
    end
    $display("test port bits done");
    wr(ADDR_PORT_FAST, 8'h01);
    pulse(1'b1);
    wr(ADDR_PORT_FAST, 8'h01);
    pulse(1'b0);
    wr(ADDR_PORT_FAST, 8'h00);
    wr(ADDR_PORT_FAST, 8'h01);
    pulse(1'b1);
    wr(ADDR_PORT_FAST, 8'h00);
    // a 0 written while the pulse is still low must re-arm it
    wr(ADDR_PORT_FAST, 8'h01);
    wr(ADDR_PORT_FAST, 8'h00);
    tick(3);
    wr(ADDR_PORT_FAST, 8'h01);
    pulse(1'b1);
    wr(ADDR_PORT_FAST, 8'h00);
    $display("test reset pulse done");
    port_enable = 1'b0;
    tick(3);
    wr(ADDR_PORT_FAST, 8'hC2);
    rd(ADDR_PORT_FAST);
    chk("io_rdata_valid", 8'h00, {7'h0, v});
    chk("disk_light_n", 8'h01, {7'h0, disk_light_n});
    port_enable = 1'b1;
    tick(3);
    rd(ADDR_PORT_FAST);
    chk("port", 8'h24, q);
    $display("test port enable done");
    fdc(ADDR_FDC_PRI, 8'h08);
    fdc(ADDR_FDC_SEC, 8'hF7);
    fdc(ADDR_FDC_SEC, 8'h08);
    fdc(ADDR_FDC_PRI, 8'h00);
    rd(ADDR_FDC_PRI);
    chk("io_rdata_valid", 8'h00, {7'h0, v});
    $display("test floppy gate done");
    wr(ADDR_CRAM_PAGE, 8'hFF);
    rd(ADDR_CRAM_PAGE);
    chk("page", 8'h1F, q & 8'h1F);
    rd(16'h08FF);
    chk("page_select_out", 8'h1F, {3'h0, page_select_out});
    wr(16'h0800, 8'h00);
    chk("page_select_out", 8'h1F, {3'h0, page_select_out});
    rd(16'h0900);
    chk("page_select_out", 8'h00, {3'h0, page_select_out});
    $display("test page done");
    wr(ADDR_PORT_FAST, 8'h08);
    rtc(8'h35, 1'b0);
    rtc(8'hB6, 1'b1);
    rtc(8'h3F, 1'b1);
    rtc(8'h40, 1'b0);
    wr(ADDR_PORT_FAST, 8'h00);
    rtc(8'h36, 1'b0);
    $display("test rtc guard done");
    for (int s = 0; s < 8; s += 7) begin
      grant_onehot = 8'h01 << s;
      grant_valid  = 1'b1;
      tick(1);
      grant_valid  = 1'b0;
      rd(ADDR_LAST_MG);
      chk("last_master_granted", 8'h01 << s, q);
    end
    $display("test last master done");
    summarize();
  end
endmodule

/* File: rtc_guard.sv */
`timescale 1ns/100ps
// rtc index capture and strobe gating for password protection
module rtc_guard
  import misc_io_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       index_write,
  input  wire logic [6:0] index_data,
  input  wire logic       protect,
  input  wire logic       rd_req,
  input  wire logic       wr_req,
  output logic            rtc_read_strobe_n,
  output logic            rtc_write_strobe_n
);
  // ----------------------------------------------------------------
  // index and gating
  // ----------------------------------------------------------------
  logic [6:0] index_q;
  wire        in_window = (index_q >= RTC_PROT_LO) && (index_q <= RTC_PROT_HI);
  wire        blocked   = protect && in_window;

  // index tracks port 70h low bits
  always_ff @(posedge clk) begin
    if (reset) index_q <= 7'h00;
    else if (index_write) index_q <= index_data;
  end

  // strobes registered so outputs come from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      rtc_read_strobe_n  <= 1'b1;
      rtc_write_strobe_n <= 1'b1;
    end else begin
      rtc_read_strobe_n  <= !(rd_req && !blocked);
      rtc_write_strobe_n <= !(wr_req && !blocked);
    end
  end

  a_rtc_block: assert property (@(posedge clk) disable iff (reset)
    (protect && in_window) |=> (rtc_read_strobe_n && rtc_write_strobe_n))
    else $error("rtc strobe inside protected range");
endmodule
